// ### verilog/pdw_pkg.sv
// Purpose: Shared constants for the process data watchdog block
// Assumes: 20 MHz system clock, 32-bit AXI4-Lite register bus
// Notes: Base tick timing is kept in 10 ns units to stay exact
package pdw_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] ADDR_MULT = 8'h00;
   localparam logic [7:0] ADDR_SM_TIMEOUT = 8'h04;
   localparam logic [7:0] ADDR_LOCAL_TIMEOUT = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_MASK = 8'h10;
   localparam logic [7:0] ADDR_STATE = 8'h14;
   // ==========================================================
   // Field positions
   localparam int BIT_SM = 0;
   localparam int BIT_LOCAL = 1;
   localparam int BIT_FORCED = 2;
   // ==========================================================
   // Reset values
   localparam logic [15:0] MULT_RESET = 16'h09c2;
   localparam logic [15:0] SM_TIMEOUT_RESET = 16'h03e8;
   localparam logic [15:0] LOCAL_TIMEOUT_RESET = 16'h03e8;
   localparam logic [1:0] MASK_RESET = 2'h0;
   // ==========================================================
   // Timing: terminal tick 40 ns, system clock 50 ns
   localparam int TERM_TICK_NS = 40;
   localparam int SYS_PERIOD_NS = 50;
   localparam int STEP_NS = 10;
   localparam logic [19:0] SYS_STEP = 20'(SYS_PERIOD_NS / STEP_NS);
   localparam logic [19:0] TERM_STEP = 20'(TERM_TICK_NS / STEP_NS);
   localparam logic [15:0] MULT_OFFSET = 16'h0002;
   // ==========================================================
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef logic [15:0] pdw_count_type;
endpackage : pdw_pkg

// ### verilog/pdw_tick_if.sv
// Purpose: Carries shared multiplier and base tick between modules
// Assumes: One prescaler source, any number of timer sinks
// Notes: Single clock domain
`timescale 1ns/1ps
interface pdw_tick_if;
   import pdw_pkg::*;
   pdw_count_type multiplier;
   logic tick;
   modport src (input multiplier, output tick);
   modport sink (input tick);
endinterface : pdw_tick_if

// ### verilog/pdw_prescaler.sv
// Purpose: Base tick generator shared by both watchdogs
// Assumes: Multiplier is never zero
// Notes: Fractional accumulator, average period exact
`timescale 1ns/1ps
module pdw_prescaler (
   input wire logic sys_clk,
   input wire logic rst_b,
   pdw_tick_if.src tk
);
   import pdw_pkg::*;

   function automatic logic [19:0] tick_limit(input pdw_count_type m);
      tick_limit = TERM_STEP * (20'(m) + 20'(MULT_OFFSET));
   endfunction : tick_limit

   logic [19:0] acc_reg;
   logic [19:0] acc_next;
   logic tick_reg;
   wire logic [19:0] acc_sum = acc_reg + SYS_STEP;
   wire logic [19:0] limit = tick_limit(tk.multiplier);
   wire logic wrap = acc_sum >= limit;
   // Shrinking the multiplier can strand a remainder above the new limit;
   // restarting the phase avoids a burst of back-to-back ticks
   wire logic stale = acc_reg >= limit;

   assign acc_next = stale ? 20'h00000 : (wrap ? acc_sum - limit : acc_sum);
   assign tk.tick = tick_reg;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_reg <= 20'h00000;
         tick_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         tick_reg <= wrap;
      end
   end

   // Shortest tick (multiplier 1) averages 2.4 clocks, never back to back
   AST_TICK_SPACING: assert property (@(posedge sys_clk)
      disable iff (!rst_b) tick_reg |=> !tick_reg)
      else $error("base ticks too close");
endmodule : pdw_prescaler

// ### verilog/pdw_timer.sv
// Purpose: One watchdog timer counting base ticks
// Assumes: Restart is a one-cycle pulse from same-clock logic
// Notes: Timeout zero disables the timer
`timescale 1ns/1ps
module pdw_timer (
   input wire logic sys_clk,
   input wire logic rst_b,
   pdw_tick_if.sink tk,
   input wire logic restart,
   input wire pdw_pkg::pdw_count_type timeout,
   output logic expired
);
   import pdw_pkg::*;

   pdw_count_type cnt_reg;
   pdw_count_type cnt_next;
   logic expired_reg;
   logic expired_next;
   wire logic enabled = timeout != 16'h0000;
   wire logic reached = enabled && (cnt_reg >= timeout);

   assign cnt_next = restart ? 16'h0000 :
      (tk.tick && cnt_reg != 16'hffff) ? cnt_reg + 16'h0001 : cnt_reg;
   assign expired_next = !restart && (reached || (expired_reg && enabled));
   assign expired = expired_reg;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= 16'h0000;
         expired_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         expired_reg <= expired_next;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_overdue;
      enabled && cnt_reg >= timeout && !restart;
   endsequence
   sequence s_restarted;
      cnt_reg == 16'h0000 && !expired_reg;
   endsequence

   AST_RESTART_CLEARS: assert property (restart |=> s_restarted)
      else $error("restart did not clear count");
   AST_EXPIRES: assert property (s_overdue |=> expired_reg)
      else $error("timeout did not trigger");
   AST_DISABLED: assert property (!enabled |=> !expired_reg)
      else $error("disabled watchdog triggered");
   AST_HOLDS: assert property (
      expired_reg && enabled && !restart |=> expired_reg)
      else $error("safe state dropped without access");
   AST_NO_EARLY: assert property (
      enabled && cnt_reg < timeout && !expired_reg |=> !expired_reg)
      else $error("watchdog triggered early");
endmodule : pdw_timer

// ### verilog/pdw_watchdog.sv
// Purpose: Output-safety watchdogs of a fieldbus slave controller
// Assumes: Access pulses come from logic on sys_clk
// Notes: AXI4-Lite registers, one level interrupt
// ==========================================================
// Operation
// - Successful fieldbus exchange restarts sync-manager count
// - Sync-manager timeout forces all outputs false
// - Expiry leaves operational state untouched
// - Local interface silence triggers its watchdog
// - Base tick is multiplier plus two 40 ns
// - Shared multiplier, separate timeout per watchdog
// - Multiplier resets to 2498, 100 us
// - Both timeouts reset to 1000 ticks
// - Timeout 0..65535, multiplier 1..65535
// - Timeout zero disables the watchdog
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module pdw_watchdog #(
   parameter int OUT_WIDTH = 8,
   parameter int STATE_WIDTH = 4
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic sm_access_ok,
   input wire logic local_access_ok,
   input wire logic [OUT_WIDTH-1:0] out_request,
   output logic [OUT_WIDTH-1:0] out_drive,
   input wire logic [STATE_WIDTH-1:0] operational_state_in,
   output logic [STATE_WIDTH-1:0] operational_state,
   output logic irq,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import pdw_pkg::*;

   // ==========================================================
   // Helpers
   function automatic pdw_count_type merge16(input pdw_count_type old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
      merge16 = old;
      if (strb[0]) begin
         merge16[7:0] = data[7:0];
      end
      if (strb[1]) begin
         merge16[15:8] = data[15:8];
      end
   endfunction : merge16

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == ADDR_MULT) || (a == ADDR_SM_TIMEOUT) ||
         (a == ADDR_LOCAL_TIMEOUT) || (a == ADDR_STATUS) ||
         (a == ADDR_MASK) || (a == ADDR_STATE);
   endfunction : addr_known

   // ==========================================================
   // Register state
   pdw_count_type mult_reg;
   pdw_count_type mult_next;
   pdw_count_type sm_timeout_reg;
   pdw_count_type sm_timeout_next;
   pdw_count_type local_timeout_reg;
   pdw_count_type local_timeout_next;
   logic [1:0] status_reg;
   logic [1:0] status_next;
   logic [1:0] mask_reg;
   logic [1:0] mask_next;

   // ==========================================================
   // Write channel
   logic aw_held_reg;
   logic [7:0] aw_addr_reg;
   logic w_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;

   wire logic aw_take = s_axi_awvalid && s_axi_awready;
   wire logic w_take = s_axi_wvalid && s_axi_wready;
   wire logic do_write = aw_held_reg && w_held_reg && !bvalid_reg;
   wire logic wr_mult = do_write && aw_addr_reg == ADDR_MULT;
   wire logic wr_sm = do_write && aw_addr_reg == ADDR_SM_TIMEOUT;
   wire logic wr_local = do_write && aw_addr_reg == ADDR_LOCAL_TIMEOUT;
   wire logic wr_mask = do_write && aw_addr_reg == ADDR_MASK;
   wire pdw_count_type mult_wval = merge16(mult_reg, w_data_reg,
                                           w_strb_reg);

   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready = !w_held_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end else if (aw_take) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr[7:0];
      end else if (do_write) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end else if (w_take) begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= addr_known(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Read channel
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_next;

   wire logic ar_take = s_axi_arvalid && s_axi_arready;
   wire logic [7:0] ar_addr = s_axi_araddr[7:0];
   wire logic rd_status = ar_take && ar_addr == ADDR_STATUS;

   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // ==========================================================
   // Watchdog core
   logic sm_expired;
   logic local_expired;
   logic sm_expired_d_reg;
   logic local_expired_d_reg;
   logic [OUT_WIDTH-1:0] out_drive_reg;
   logic [STATE_WIDTH-1:0] op_state_reg;

   pdw_tick_if tk ();

   assign tk.multiplier = mult_reg;

   pdw_prescaler u_prescaler (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .tk(tk.src)
   );

   pdw_timer u_sm_timer (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .tk(tk.sink),
      .restart(sm_access_ok),
      .timeout(sm_timeout_reg),
      .expired(sm_expired)
   );

   pdw_timer u_local_timer (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .tk(tk.sink),
      .restart(local_access_ok),
      .timeout(local_timeout_reg),
      .expired(local_expired)
   );

   wire logic force_safe = sm_expired || local_expired;
   wire logic [1:0] events = {local_expired && !local_expired_d_reg,
                              sm_expired && !sm_expired_d_reg};
   wire logic [31:0] state_word = {29'h00000000, force_safe,
                                   local_expired, sm_expired};

   // Zero multiplier would allow back-to-back ticks, so such writes keep old value
   assign mult_next = (wr_mult && mult_wval != 16'h0000) ?
      mult_wval : mult_reg;
   assign sm_timeout_next = wr_sm ?
      merge16(sm_timeout_reg, w_data_reg, w_strb_reg) : sm_timeout_reg;
   assign local_timeout_next = wr_local ?
      merge16(local_timeout_reg, w_data_reg, w_strb_reg) :
      local_timeout_reg;
   assign mask_next = (wr_mask && w_strb_reg[0]) ?
      w_data_reg[1:0] : mask_reg;
   // Event in the clearing read cycle survives
   assign status_next = (rd_status ? 2'h0 : status_reg) | events;

   always_comb begin
      case (ar_addr)
         ADDR_MULT: rdata_next = {16'h0000, mult_reg};
         ADDR_SM_TIMEOUT: rdata_next = {16'h0000, sm_timeout_reg};
         ADDR_LOCAL_TIMEOUT: rdata_next = {16'h0000, local_timeout_reg};
         ADDR_STATUS: rdata_next = {30'h00000000, status_reg};
         ADDR_MASK: rdata_next = {30'h00000000, mask_reg};
         ADDR_STATE: rdata_next = state_word;
         default: rdata_next = 32'h00000000;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rdata_next;
         rresp_reg <= addr_known(ar_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mult_reg <= MULT_RESET;
         sm_timeout_reg <= SM_TIMEOUT_RESET;
         local_timeout_reg <= LOCAL_TIMEOUT_RESET;
         mask_reg <= MASK_RESET;
      end else begin
         mult_reg <= mult_next;
         sm_timeout_reg <= sm_timeout_next;
         local_timeout_reg <= local_timeout_next;
         mask_reg <= mask_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         status_reg <= 2'h0;
         sm_expired_d_reg <= 1'b0;
         local_expired_d_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
         sm_expired_d_reg <= sm_expired;
         local_expired_d_reg <= local_expired;
      end
   end

   // ==========================================================
   // Outputs
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_drive_reg <= '0;
         op_state_reg <= '0;
      end else begin
         out_drive_reg <= force_safe ? '0 : out_request;
         op_state_reg <= operational_state_in;
      end
   end

   assign out_drive = out_drive_reg;
   assign operational_state = op_state_reg;
   assign irq = |(status_reg & mask_reg);

   // ==========================================================
   // Checks
   AST_SAFE_OUT: assert property (@(posedge sys_clk)
      disable iff (!rst_b) force_safe |=> out_drive == '0)
      else $error("outputs not forced off");
   AST_STATE_KEPT: assert property (@(posedge sys_clk)
      disable iff (!rst_b)
      sm_expired |=> operational_state == $past(operational_state_in))
      else $error("expiry altered operational state");
   AST_MULT_NONZERO: assert property (@(posedge sys_clk)
      disable iff (!rst_b) mult_reg != 16'h0000)
      else $error("multiplier reached zero");
   AST_SHARED_TICK: assert property (@(posedge sys_clk)
      disable iff (!rst_b)
      wr_mult && mult_wval != 16'h0000 |=> tk.multiplier == $past(mult_wval))
      else $error("multiplier write not taken");
   AST_STATUS_SET: assert property (@(posedge sys_clk)
      disable iff (!rst_b) events[0] |=> status_reg[0])
      else $error("event lost from status");
   // Outputs follow the request one clock later while both watchdogs are quiet
   AST_OUT_FOLLOWS: assert property (@(posedge sys_clk)
      disable iff (!rst_b)
      !force_safe |=> out_drive == $past(out_request))
      else $error("outputs not passed through");
   AST_LOCAL_SAFE: assert property (@(posedge sys_clk)
      disable iff (!rst_b) local_expired |=> out_drive == '0)
      else $error("local expiry left outputs on");
   AST_ZERO_MULT_KEPT: assert property (@(posedge sys_clk)
      disable iff (!rst_b)
      wr_mult && mult_wval == 16'h0000 |=> mult_reg == $past(mult_reg))
      else $error("zero multiplier accepted");
   // A read of status clears it unless a new event lands alongside
   AST_STATUS_CLEAR: assert property (@(posedge sys_clk)
      disable iff (!rst_b)
      rd_status && events == 2'h0 |=> status_reg == 2'h0)
      else $error("status not cleared by read");

   // ==========================================================
   // Bus checks
   // Pending handshake steps: answer shown, master not yet ready
   sequence s_wr_pending;
      bvalid_reg && !s_axi_bready;
   endsequence
   sequence s_rd_pending;
      rvalid_reg && !s_axi_rready;
   endsequence

   AST_BVALID_HOLD: assert property (@(posedge sys_clk)
      disable iff (!rst_b)
      s_wr_pending |=> bvalid_reg && $stable(bresp_reg))
      else $error("write response dropped early");
   AST_RVALID_HOLD: assert property (@(posedge sys_clk)
      disable iff (!rst_b)
      s_rd_pending |=> rvalid_reg && $stable(rdata_reg))
      else $error("read data dropped early");
   AST_WR_SLVERR: assert property (@(posedge sys_clk)
      disable iff (!rst_b)
      do_write && !addr_known(aw_addr_reg) |=> bresp_reg == RESP_SLVERR)
      else $error("unmapped write not refused");
   AST_RD_SLVERR: assert property (@(posedge sys_clk)
      disable iff (!rst_b)
      ar_take && !addr_known(ar_addr) |=> rresp_reg == RESP_SLVERR)
      else $error("unmapped read not refused");
endmodule : pdw_watchdog

// ### sim/pdw_far_model.sv
// Purpose: Fieldbus master and local processor access pulse source
// Assumes: Pulses are one cycle wide, every third clock when enabled
// Notes: Stopping an enable models a broken line or a hung processor
`timescale 1ns/1ps
module pdw_far_model (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic sm_en,
   input wire logic local_en,
   output logic sm_access_ok,
   output logic local_access_ok
);
   logic [1:0] gap_reg;
   logic [1:0] gap_next;
   logic slot;
   // ==========================================================
   // Pacing
   assign gap_next = (gap_reg == 2'h2) ? 2'h0 : gap_reg + 2'h1;
   assign slot = (gap_reg == 2'h0);
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_reg <= 2'h0;
         sm_access_ok <= 1'b0;
         local_access_ok <= 1'b0;
      end else begin
         gap_reg <= gap_next;
         sm_access_ok <= sm_en && slot;
         local_access_ok <= local_en && slot;
      end
   end
endmodule : pdw_far_model

// ### sim/pdw_watchdog_tb_top.sv
// Purpose: Self-checking bench for the process data watchdog block
// Assumes: AXI4-Lite master tasks, far side pulses from the model
// Notes: Small multiplier and timeouts keep the run short
`timescale 1ns/1ps
module pdw_watchdog_tb_top;
   import pdw_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic sm_en = 1'b0;
   logic local_en = 1'b0;
   logic sm_access_ok;
   logic local_access_ok;
   logic [7:0] out_request = 8'ha5;
   logic [7:0] out_drive;
   logic [3:0] operational_state_in = 4'h8;
   logic [3:0] operational_state;
   logic irq;
   logic [31:0] s_axi_awaddr = 32'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [31:0] s_axi_araddr = 32'h0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   int error_cnt = 0;
   int num_checks = 0;
   logic [15:0] mv [2] = '{16'h0001, 16'h0003};
   logic [15:0] tv [2] = '{16'h0014, 16'h000a};

   always #25 sys_clk = ~sys_clk;

   pdw_watchdog pdw_watchdog_inst (.sys_clk(sys_clk), .rst_b(rst_b),
      .sm_access_ok(sm_access_ok), .local_access_ok(local_access_ok),
      .out_request(out_request), .out_drive(out_drive),
      .operational_state_in(operational_state_in),
      .operational_state(operational_state), .irq(irq),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));

   pdw_far_model pdw_far_model_inst (.sys_clk(sys_clk), .rst_b(rst_b),
      .sm_en(sm_en), .local_en(local_en), .sm_access_ok(sm_access_ok),
      .local_access_ok(local_access_ok));

   // ==========================================================
   // Checking and bus tasks
   task automatic results();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Values read right after the edge are the ones sampled at it
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic aw_on;
      logic w_on;
      logic [1:0] er;
      er = (a <= ADDR_STATE && a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      @(posedge sys_clk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw_on = 1'b1;
      w_on = 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge sys_clk);
         if (s_axi_bvalid === 1'b1) break;
         if (aw_on && s_axi_awready === 1'b1) begin
            s_axi_awvalid <= 1'b0;
            aw_on = 1'b0;
         end
         if (w_on && s_axi_wready === 1'b1) begin
            s_axi_wvalid <= 1'b0;
            w_on = 1'b0;
         end
      end
      s_axi_bready <= 1'b0;
      chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input logic [1:0] er);
      int n;
      logic ar_on;
      @(posedge sys_clk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      ar_on = 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge sys_clk);
         if (s_axi_rvalid === 1'b1) break;
         if (ar_on && s_axi_arready === 1'b1) begin
            s_axi_arvalid <= 1'b0;
            ar_on = 1'b0;
         end
      end
      s_axi_rready <= 1'b0;
      chk("rvalid", 32'h1, {31'h0, s_axi_rvalid});
      chk("rdata", exp, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask : rd_chk

   // Expiry time measured from the moment traffic stops
   task automatic expire(input logic [15:0] m, input logic [15:0] t);
      int n;
      int lo;
      int hi;
      logic ok;
      wr(ADDR_MULT, {16'h0, m});
      wr(ADDR_SM_TIMEOUT, {16'h0, t});
      sm_en <= 1'b1;
      repeat (60) @(posedge sys_clk);
      chk("out_drive_fed", 32'ha5, {24'h0, out_drive});
      sm_en <= 1'b0;
      for (n = 0; n < 400 && out_drive !== 8'h00; n++) @(posedge sys_clk);
      lo = ((t - 1) * (m + 2) * TERM_TICK_NS) / SYS_PERIOD_NS - 3;
      hi = (t * (m + 2) * TERM_TICK_NS) / SYS_PERIOD_NS + 4;
      ok = (n >= lo) && (n <= hi);
      chk("expiry_time", 32'h1, {31'h0, ok});
   endtask : expire

   // ==========================================================
   // Tests
   initial begin
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd_chk(ADDR_MULT, 32'h09c2, RESP_OKAY);
      rd_chk(ADDR_SM_TIMEOUT, 32'h03e8, RESP_OKAY);
      rd_chk(ADDR_LOCAL_TIMEOUT, 32'h03e8, RESP_OKAY);
      rd_chk(ADDR_MASK, 32'h0, RESP_OKAY);
      rd_chk(8'h18, 32'h0, RESP_SLVERR);
      wr(8'h18, 32'h1);
      wr(ADDR_MULT, 32'h0);
      rd_chk(ADDR_MULT, 32'h09c2, RESP_OKAY);
      wr(ADDR_SM_TIMEOUT, 32'hffff);
      rd_chk(ADDR_SM_TIMEOUT, 32'hffff, RESP_OKAY);
      s_axi_wstrb <= 4'h2;
      wr(ADDR_SM_TIMEOUT, 32'h0012);
      s_axi_wstrb <= 4'hf;
      rd_chk(ADDR_SM_TIMEOUT, 32'h00ff, RESP_OKAY);
      wr(ADDR_LOCAL_TIMEOUT, 32'h0);
      wr(ADDR_MASK, 32'h1);
      for (int i = 0; i < 2; i++) begin
         expire(mv[i], tv[i]);
         chk("op_state", 32'h8, {28'h0, operational_state});
         chk("irq_set", 32'h1, {31'h0, irq});
         rd_chk(ADDR_STATE, 32'h5, RESP_OKAY);
         rd_chk(ADDR_STATUS, 32'h1, RESP_OKAY);
         rd_chk(ADDR_STATUS, 32'h0, RESP_OKAY);
         repeat (2) @(posedge sys_clk);
         chk("irq_clear", 32'h0, {31'h0, irq});
         repeat (20) @(posedge sys_clk);
         chk("out_held_off", 32'h0, {24'h0, out_drive});
         sm_en <= 1'b1;
         repeat (6) @(posedge sys_clk);
         chk("out_restored", 32'ha5, {24'h0, out_drive});
      end
      wr(ADDR_SM_TIMEOUT, 32'h0);
      sm_en <= 1'b0;
      repeat (300) @(posedge sys_clk);
      chk("out_disabled_wd", 32'ha5, {24'h0, out_drive});
      rd_chk(ADDR_STATE, 32'h0, RESP_OKAY);
      local_en <= 1'b1;
      wr(ADDR_LOCAL_TIMEOUT, 32'h6);
      repeat (30) @(posedge sys_clk);
      chk("out_local_fed", 32'ha5, {24'h0, out_drive});
      local_en <= 1'b0;
      for (int n = 0; n < 100 && out_drive !== 8'h00; n++) begin
         @(posedge sys_clk);
      end
      chk("out_local_off", 32'h0, {24'h0, out_drive});
      chk("op_state_local", 32'h8, {28'h0, operational_state});
      rd_chk(ADDR_STATE, 32'h6, RESP_OKAY);
      chk("irq_masked", 32'h0, {31'h0, irq});
      wr(ADDR_MASK, 32'h3);
      repeat (2) @(posedge sys_clk);
      chk("irq_local", 32'h1, {31'h0, irq});
      rd_chk(ADDR_STATUS, 32'h2, RESP_OKAY);
      local_en <= 1'b1;
      out_request <= 8'h3c;
      repeat (6) @(posedge sys_clk);
      chk("out_local_back", 32'h3c, {24'h0, out_drive});
      results();
   end

   // Whole sequence needs under a thousand cycles
   initial begin
      #(SYS_PERIOD_NS * 20000);
      error_cnt++;
      results();
   end
endmodule : pdw_watchdog_tb_top
